// >>> mpa_pkg.sv
package mpa_pkg;
  // Frame delimiters used by the character framing.
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_LF = 8'h0A;
  localparam logic [7:0] CHR_COLON = 8'h3A;
  // Line silence that closes a binary frame, and its cycle count at 50 MHz.
  localparam int SILENCE_US = 10000;
  localparam int CLK_MHZ = 50;
  localparam int SILENCE_CYC_DFLT = SILENCE_US * CLK_MHZ;
  // Check value seed and reflected polynomial.
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // Function codes and exception answers.
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  // Parameter word ranges.
  localparam logic [15:0] G0_RD_LO = 16'h0000;
  localparam logic [15:0] G0_WR_LO = 16'h0002;
  localparam logic [15:0] G0_HI = 16'h0011;
  localparam logic [15:0] G1_LO = 16'h0100;
  localparam logic [15:0] G1_HI = 16'h013E;
  localparam logic [15:0] G2_LO = 16'h0200;
  localparam logic [15:0] G2_HI = 16'h0241;
  localparam logic [15:0] G3_LO = 16'h0300;
  localparam logic [15:0] G3_HI = 16'h0307;
  localparam logic [15:0] G4_RD_LO = 16'h0400;
  localparam logic [15:0] G4_WR_LO = 16'h0405;
  localparam logic [15:0] G4_HI = 16'h0417;
  // Parameters with side effects.
  localparam logic [15:0] CURRENT_FAULT_ADDR = 16'h0001;
  localparam logic [15:0] UNLOCK_KEY_ADDR = 16'h0208;
  localparam logic [15:0] STATION_ADDR = 16'h0300;
  localparam logic [15:0] LINK_SPEED_ADDR = 16'h0301;
  localparam logic [15:0] LINK_FORMAT_ADDR = 16'h0302;
  localparam logic [15:0] FAULT_HIST_LO = 16'h0400;
  localparam logic [15:0] FAULT_HIST_HI = 16'h0404;
  localparam logic [15:0] FORCED_OUT_ADDR = 16'h0406;
  localparam logic [15:0] ADJ_SELECT_ADDR = 16'h040A;
  localparam logic [15:0] TRIM_LO = 16'h040B;
  localparam logic [15:0] TRIM_HI = 16'h0415;
  localparam logic [15:0] UNLOCK_ADJ = 16'h0014;
  localparam logic [15:0] UNLOCK_TRIM = 16'h0016;
  localparam logic [15:0] FORCE_MAX = 16'h0005;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  localparam int FMT_RTU_BIT = 3;
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [3:0] RX_MAX = 4'h8;
  // Bus register offsets and interrupt bit positions.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_CLR = 8'h0C;
  localparam logic [7:0] OFS_INT_EN = 8'h10;
  localparam logic [7:0] OFS_FAULT = 8'h14;
  localparam logic [7:0] OFS_LINK = 8'h18;
  localparam int EV_DONE = 0;
  localparam int EV_CHKERR = 1;
  localparam int EV_REFUSED = 2;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mpa_byte_t;

  typedef enum {TX_IDLE, TX_START, TX_BODY, TX_CHK, TX_CR, TX_LF} mpa_tx_t;

  function automatic logic in_rng(logic [15:0] a, logic [15:0] lo,
                                  logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [3:0] hex_val(logic [7:0] ch);
    return (ch >= 8'h41) ? ch[3:0] + 4'h9 : ch[3:0];
  endfunction

  function automatic logic [7:0] hex_chr(logic [3:0] n);
    return (n < 4'hA) ? {4'h3, n} : 8'h37 + {4'h0, n};
  endfunction

  // Group 2 runs past index 63, so the index keeps seven bits to avoid
  // aliasing its top words onto its first ones.
  function automatic logic [9:0] pidx(logic [15:0] a);
    return {a[10:8], a[6:0]};
  endfunction
endpackage

// >>> mpa_modbus_slave.sv
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - In character framing a frame ends on a carriage return then a line feed.
// - In binary framing a line silence longer than 10 ms ends the frame.
// - The binary check starts at FFFF, folds each byte in low and shifts eight times with A001.
// - The binary check goes out low byte first, then high byte.
// - Function 06 writes one word and the answer echoes address and value.
// - Word address is group in the high byte and index in the low byte; group 0 writes only at 0002-0011.
// - Groups 1, 2 and 3 are readable and writable at 0100-013E, 0200-0241 and 0300-0307.
// - Group 4 is writable only at 0405-0417.
// - Group 0 reads at 0000-0011 and group 4 reads at 0400-0417.
// - A new link speed takes effect only after the current exchange.
// - A new link format takes effect only after the current exchange.
// - Values 1 to 5 in the forced output test force outputs 0 to 4; 0 ends the test.
// - The adjust select parameter changes only after key 14H and a restart.
// - The offset trim parameters change only after key 16H and a restart.
// - Current fault and fault history are readable over the link.
module mpa_modbus_slave
  import mpa_pkg::*;
#(
  parameter int SILENCE_CYC = SILENCE_CYC_DFLT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire mpa_byte_t rx_byte,
  output mpa_byte_t tx_byte,
  input wire logic tx_ready,
  output logic [15:0] link_speed,
  output logic [15:0] link_format,
  output logic [4:0] forced_do,
  output logic irq
);
  localparam logic [19:0] SIL_MAX = 20'(SILENCE_CYC);

  logic ascii;
  logic [15:0] mem_q [0:639];
  // Receive state.
  logic [7:0] rbuf_q [0:7];
  logic [7:0] rbuf_d [0:7];
  logic [3:0] rcnt_q, rcnt_d;
  logic inf_q, inf_d, cr_q, cr_d, nib_q, nib_d, act_q, act_d;
  logic [3:0] hi_q, hi_d;
  logic [7:0] lrc_q, lrc_d;
  logic [15:0] crc_q, crc_d;
  logic [19:0] sil_q, sil_d;
  logic frame_end, got;
  logic [7:0] rb;
  // Transmit state.
  mpa_tx_t tst_q, tst_d;
  logic [7:0] tbuf_q [0:5];
  logic [7:0] tbuf_d [0:5];
  logic [2:0] pos_q, pos_d, len_q, len_d;
  logic half_q, half_d, tv_q, tv_d;
  logic [7:0] td_q, td_d, tlrc_q, tlrc_d, cb;
  logic [15:0] tcrc_q, tcrc_d;
  logic start, load, wr_ok, rd_ok, mem_we, chk_ok, refused;
  logic [15:0] pa, pv, rd_word;
  // Bus, interrupt and side-effect state.
  logic wr_q, wr_d, pend_q, pend_d, irq_q, irq_d, apply;
  logic [7:0] ad_q, ad_d;
  logic [31:0] rdat_q, rdat_d;
  logic [2:0] stat_q, stat_d, en_q, en_d, ev, clr;
  logic [15:0] unlock_q, unlock_d, cur_q, cur_d, spd_q, spd_d, fmt_q, fmt_d;
  logic [15:0] hist_q [0:4];
  logic [15:0] hist_d [0:4];
  logic [4:0] fdo_q, fdo_d;
  logic [15:0] fv;

  assign ascii = !fmt_q[FMT_RTU_BIT];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdat_q;
  assign tx_byte = {tv_q, td_q};
  assign link_speed = spd_q;
  assign link_format = fmt_q;
  assign forced_do = fdo_q;
  assign irq = irq_q;

  // Receive framing: hex pairing and sum in character mode, check and silence
  // timing in binary mode; bytes beyond eight only mark the frame as too long.
  always_comb begin
    rbuf_d = rbuf_q;
    rcnt_d = rcnt_q;
    inf_d = inf_q;
    cr_d = cr_q;
    nib_d = nib_q;
    hi_d = hi_q;
    lrc_d = lrc_q;
    crc_d = crc_q;
    sil_d = sil_q;
    act_d = act_q;
    frame_end = 1'b0;
    got = 1'b0;
    rb = rx_byte.data;
    if (ascii) begin
      act_d = 1'b0;
      sil_d = '0;
      if (rx_byte.valid) begin
        cr_d = 1'b0;
        if (rx_byte.data == CHR_COLON) begin
          inf_d = 1'b1;
          rcnt_d = '0;
          nib_d = 1'b0;
          lrc_d = '0;
        end else if (inf_q) begin
          if (rx_byte.data == CHR_CR) begin
            cr_d = 1'b1;
          end else if (rx_byte.data == CHR_LF && cr_q) begin
            frame_end = 1'b1;
            inf_d = 1'b0;
          end else if (!nib_q) begin
            hi_d = hex_val(rx_byte.data);
            nib_d = 1'b1;
          end else begin
            rb = {hi_q, hex_val(rx_byte.data)};
            got = 1'b1;
            nib_d = 1'b0;
            lrc_d = lrc_q + rb;
          end
        end
      end
    end else begin
      inf_d = 1'b0;
      if (rx_byte.valid) begin
        sil_d = '0;
        act_d = 1'b1;
        got = 1'b1;
        crc_d = crc_byte(act_q ? crc_q : CRC_INIT, rb);
        if (!act_q) begin
          rcnt_d = '0;
        end
      end else if (act_q) begin
        if (sil_q >= SIL_MAX) begin
          frame_end = 1'b1;
          act_d = 1'b0;
        end else begin
          sil_d = sil_q + 20'h00001;
        end
      end
    end
    if (got) begin
      if (rcnt_d < RX_MAX) begin
        rbuf_d[rcnt_d[2:0]] = rb;
      end
      if (rcnt_d <= RX_MAX) begin
        rcnt_d = rcnt_d + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rbuf_q <= '{default: 8'h00};
      rcnt_q <= '0;
      inf_q <= 1'b0;
      cr_q <= 1'b0;
      nib_q <= 1'b0;
      hi_q <= '0;
      lrc_q <= '0;
      crc_q <= CRC_INIT;
      sil_q <= '0;
      act_q <= 1'b0;
    end else begin
      rbuf_q <= rbuf_d;
      rcnt_q <= rcnt_d;
      inf_q <= inf_d;
      cr_q <= cr_d;
      nib_q <= nib_d;
      hi_q <= hi_d;
      lrc_q <= lrc_d;
      crc_q <= crc_d;
      sil_q <= sil_d;
      act_q <= act_d;
    end
  end

  // Command decode and access checks; the parameter memory never sees a
  // refused write.
  assign pa = {rbuf_q[2], rbuf_q[3]};
  assign pv = {rbuf_q[4], rbuf_q[5]};
  assign chk_ok = ascii ? (lrc_q == 8'h00 && rcnt_q == 4'h7)
                        : (crc_q == 16'h0000 && rcnt_q == RX_MAX);
  assign start = frame_end && chk_ok && rbuf_q[0] == mem_q[pidx(STATION_ADDR)][7:0]
                 && tst_q == TX_IDLE && !tv_q;
  assign wr_ok = (in_rng(pa, G0_WR_LO, G0_HI)
                  || in_rng(pa, G1_LO, G1_HI) || in_rng(pa, G2_LO, G2_HI)
                  || in_rng(pa, G3_LO, G3_HI)
                  || in_rng(pa, G4_WR_LO, G4_HI))
                 && (pa != ADJ_SELECT_ADDR || unlock_q == UNLOCK_ADJ)
                 && (!in_rng(pa, TRIM_LO, TRIM_HI) || unlock_q == UNLOCK_TRIM);
  assign rd_ok = pv == ONE_WORD && (in_rng(pa, G0_RD_LO, G0_HI)
                 || in_rng(pa, G1_LO, G1_HI) || in_rng(pa, G2_LO, G2_HI)
                 || in_rng(pa, G3_LO, G3_HI) || in_rng(pa, G4_RD_LO, G4_HI));
  assign rd_word = (pa == CURRENT_FAULT_ADDR) ? cur_q
                 : in_rng(pa, FAULT_HIST_LO, FAULT_HIST_HI) ? hist_q[pa[2:0]]
                 : mem_q[pidx(pa)];
  assign mem_we = start && rbuf_q[1] == FN_WRITE && wr_ok;
  assign load = tst_q != TX_IDLE && (!tv_q || tx_ready);

  // Answer builder and character or binary serialiser.
  always_comb begin
    tst_d = tst_q;
    tbuf_d = tbuf_q;
    pos_d = pos_q;
    len_d = len_q;
    half_d = half_q;
    tcrc_d = tcrc_q;
    tlrc_d = tlrc_q;
    tv_d = tv_q && !tx_ready;
    td_d = td_q;
    cb = tbuf_q[pos_q];
    refused = 1'b0;
    if (start) begin
      tbuf_d[0] = rbuf_q[0];
      tbuf_d[1] = rbuf_q[1] | EXC_FLAG;
      tbuf_d[2] = EXC_FUNC;
      len_d = 3'h3;
      if (rbuf_q[1] == FN_WRITE && wr_ok) begin
        tbuf_d = rbuf_q[0:5];
        len_d = 3'h6;
      end else if (rbuf_q[1] == FN_READ && rd_ok) begin
        tbuf_d[1] = FN_READ;
        tbuf_d[2] = 8'h02;
        tbuf_d[3] = rd_word[15:8];
        tbuf_d[4] = rd_word[7:0];
        len_d = 3'h5;
      end else begin
        refused = 1'b1;
        if (rbuf_q[1] == FN_WRITE || rbuf_q[1] == FN_READ) begin
          tbuf_d[2] = EXC_ADDR;
        end
      end
      pos_d = '0;
      half_d = 1'b0;
      tcrc_d = CRC_INIT;
      tlrc_d = '0;
      tst_d = ascii ? TX_START : TX_BODY;
    end else if (load) begin
      tv_d = 1'b1;
      case (tst_q)
        TX_START: begin
          td_d = CHR_COLON;
          tst_d = TX_BODY;
        end
        TX_BODY: begin
          if (ascii) begin
            td_d = hex_chr(half_q ? cb[3:0] : cb[7:4]);
            half_d = !half_q;
            if (half_q) begin
              tlrc_d = tlrc_q - cb;
            end
          end else begin
            td_d = cb;
            tcrc_d = crc_byte(tcrc_q, cb);
          end
          if (!ascii || half_q) begin
            pos_d = pos_q + 3'h1;
            if (pos_q == len_q - 3'h1) begin
              tst_d = TX_CHK;
            end
          end
        end
        TX_CHK: begin
          if (ascii) begin
            td_d = hex_chr(half_q ? tlrc_q[3:0] : tlrc_q[7:4]);
          end else begin
            td_d = half_q ? tcrc_q[15:8] : tcrc_q[7:0];
          end
          half_d = !half_q;
          if (half_q) begin
            tst_d = ascii ? TX_CR : TX_IDLE;
          end
        end
        TX_CR: begin
          td_d = CHR_CR;
          tst_d = TX_LF;
        end
        TX_LF: begin
          td_d = CHR_LF;
          tst_d = TX_IDLE;
        end
        default: begin
          tv_d = 1'b0;
          tst_d = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tst_q <= TX_IDLE;
      tbuf_q <= '{default: 8'h00};
      pos_q <= '0;
      len_q <= '0;
      half_q <= 1'b0;
      tcrc_q <= CRC_INIT;
      tlrc_q <= '0;
      tv_q <= 1'b0;
      td_q <= '0;
    end else begin
      tst_q <= tst_d;
      tbuf_q <= tbuf_d;
      pos_q <= pos_d;
      len_q <= len_d;
      half_q <= half_d;
      tcrc_q <= tcrc_d;
      tlrc_q <= tlrc_d;
      tv_q <= tv_d;
      td_q <= td_d;
    end
  end

  // Parameter memory; only an accepted single-word write changes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_q <= '{default: 16'h0000};
      mem_q[pidx(STATION_ADDR)] <= {8'h00, STATION_RST};
    end else if (mem_we) begin
      mem_q[pidx(pa)] <= pv;
    end
  end

  // Bus slave, interrupts, deferred link settings, output test and faults.
  always_comb begin
    wr_d = hsel && hready && htrans[1] && hwrite;
    ad_d = haddr[7:0];
    rdat_d = '0;
    en_d = en_q;
    clr = '0;
    unlock_d = unlock_q;
    cur_d = cur_q;
    hist_d = hist_q;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        OFS_STATUS: rdat_d = {16'h0000, unlock_q[7:0], 5'h00, ascii,
                              tst_q != TX_IDLE, inf_q | act_q};
        OFS_INT_STAT: rdat_d = {29'h00000000, stat_q};
        OFS_INT_EN: rdat_d = {29'h00000000, en_q};
        OFS_FAULT: rdat_d = {16'h0000, cur_q};
        OFS_LINK: rdat_d = {fmt_q, spd_q};
        default: rdat_d = '0;
      endcase
    end
    if (wr_q) begin
      case (ad_q)
        OFS_CTRL: begin
          if (hwdata[0]) begin
            unlock_d = mem_q[pidx(UNLOCK_KEY_ADDR)];
          end
        end
        OFS_INT_CLR: clr = hwdata[2:0];
        OFS_INT_EN: en_d = hwdata[2:0];
        OFS_FAULT: begin
          cur_d = hwdata[15:0];
          if (hwdata[15:0] != 16'h0000) begin
            hist_d[0] = hwdata[15:0];
            for (int i = 1; i < 5; i++) begin
              hist_d[i] = hist_q[i - 1];
            end
          end
        end
        default: clr = '0;
      endcase
    end
    ev = '0;
    ev[EV_DONE] = start && !refused;
    ev[EV_CHKERR] = frame_end && !chk_ok;
    ev[EV_REFUSED] = refused;
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_d & en_d);
    apply = pend_q && tst_q == TX_IDLE && !tv_q && !start;
    pend_d = (pend_q && !apply) || (mem_we && (pa == LINK_SPEED_ADDR
                                    || pa == LINK_FORMAT_ADDR));
    spd_d = apply ? mem_q[pidx(LINK_SPEED_ADDR)] : spd_q;
    fmt_d = apply ? mem_q[pidx(LINK_FORMAT_ADDR)] : fmt_q;
    fv = mem_q[pidx(FORCED_OUT_ADDR)];
    fdo_d = (fv != 16'h0000 && fv <= FORCE_MAX)
            ? 5'(5'h01 << (fv[2:0] - 3'h1)) : 5'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ad_q <= '0;
      rdat_q <= '0;
      stat_q <= '0;
      en_q <= '0;
      irq_q <= 1'b0;
      unlock_q <= '0;
      cur_q <= '0;
      hist_q <= '{default: 16'h0000};
      pend_q <= 1'b0;
      spd_q <= '0;
      fmt_q <= '0;
      fdo_q <= '0;
    end else begin
      wr_q <= wr_d;
      ad_q <= ad_d;
      rdat_q <= rdat_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
      unlock_q <= unlock_d;
      cur_q <= cur_d;
      hist_q <= hist_d;
      pend_q <= pend_d;
      spd_q <= spd_d;
      fmt_q <= fmt_d;
      fdo_q <= fdo_d;
    end
  end

  default clocking ck @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ascii_end_a: assert property (ascii && inf_q && cr_q && rx_byte.valid
    && rx_byte.data == CHR_LF |=> !inf_q) else $error("frame not closed");
  rtu_silence_a: assert property (!ascii && act_q && !rx_byte.valid
    && sil_q >= SIL_MAX |=> !act_q) else $error("silence ignored");
  crc_seed_a: assert property (!ascii && !act_q && rx_byte.valid
    |=> crc_q == crc_byte(CRC_INIT, $past(rx_byte.data)))
    else $error("check seed wrong");
  crc_order_a: assert property (!ascii && load && tst_q == TX_CHK
    && !half_q |=> td_q == tcrc_q[7:0] && tst_q == TX_CHK && half_q)
    else $error("check byte order");
  write_echo_a: assert property (mem_we |=> tbuf_q[3] == $past(rbuf_q[3])
    && tbuf_q[5] == $past(rbuf_q[5]) && len_q == 3'h6)
    else $error("write echo wrong");
  write_range_a: assert property (mem_we |-> (pa >= G0_WR_LO)
    && !in_rng(pa, G4_RD_LO, 16'h0404)) else $error("write out of range");
  read_range_a: assert property (start && rbuf_q[1] == FN_READ
    && !in_rng(pa, G0_RD_LO, G4_HI) |=> tbuf_q[1] == (FN_READ | EXC_FLAG))
    else $error("bad read answered");
  speed_defer_a: assert property (tst_q != TX_IDLE |=> $stable(spd_q)
    && $stable(fmt_q)) else $error("link changed mid exchange");
  force_out_a: assert property (fv == 16'h0003 |=> fdo_q == 5'h04)
    else $error("forced output wrong");
  unlock_gate_a: assert property (mem_we && in_rng(pa, TRIM_LO, TRIM_HI)
    |-> unlock_q == UNLOCK_TRIM) else $error("trim written while locked");
endmodule

// >>> mpa_link_master.sv
`timescale 1ns/1ps
module mpa_link_master
  import mpa_pkg::*;
(
  input wire logic hclk,
  output mpa_byte_t rx_byte,
  output logic tx_ready,
  input wire mpa_byte_t tx_byte
);
  logic [7:0] got[$];
  bit slow = 1'b0;

  // The line starts idle and nothing is accepted before the first edge.
  initial begin
    rx_byte = '0;
    tx_ready = 1'b0;
  end

  // Collects answer bytes; a slow master offers ready every other cycle.
  always @(posedge hclk) begin
    if (tx_byte.valid && tx_ready) got.push_back(tx_byte.data);
    tx_ready <= slow ? !tx_ready : 1'b1;
  end

  // Turns a nibble into an upper-case hex character.
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // Wraps a message in the framing and check of the selected mode.
  task automatic enc(input logic [7:0] q[$], input bit rtu,
                     output logic [7:0] o[$]);
    logic [15:0] c;
    logic [7:0] s;
    c = 16'hFFFF;
    s = 8'h00;
    o = {};
    if (rtu) begin
      foreach (q[i]) begin
        c ^= {8'h00, q[i]};
        for (int k = 0; k < 8; k++) begin
          c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
      end
      o = {q, c[7:0], c[15:8]};
    end else begin
      foreach (q[i]) s += q[i];
      q.push_back(8'h00 - s);
      o.push_back(8'h3A);
      foreach (q[i]) begin
        o.push_back(hx(q[i][7:4]));
        o.push_back(hx(q[i][3:0]));
      end
      o.push_back(8'h0D);
      o.push_back(8'h0A);
    end
  endtask

  // Sends one frame; idle data is scrambled so no stale byte lingers.
  task automatic send(input logic [7:0] q[$], input bit rtu, input bit bad);
    logic [7:0] o[$];
    enc(q, rtu, o);
    if (bad) o[o.size() - 1] ^= 8'h01;
    foreach (o[i]) begin
      @(posedge hclk);
      rx_byte <= '{1'b1, o[i]};
      @(posedge hclk);
      rx_byte <= '{1'b0, ~o[i]};
    end
  endtask
endmodule

// >>> tb_mpa_modbus_slave.sv
`timescale 1ns/1ps
module tb_mpa_modbus_slave
  import mpa_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, tx_ready;
  logic [31:0] hrdata, r;
  logic [15:0] link_speed, link_format;
  logic [4:0] forced_do;
  logic [7:0] bq[$];
  mpa_byte_t rx_byte, tx_byte;
  int n_mismatch = 0;
  int checked = 0;
  bit rtu = 1'b0;
  logic [47:0] tbl[21] = '{
    48'h06_0002_1111_00, 48'h06_0011_1234_00, 48'h06_0001_5555_02,
    48'h06_0012_5555_02, 48'h03_0011_1234_00, 48'h03_0000_0000_00,
    48'h03_0012_0000_02, 48'h06_013E_00AA_00, 48'h06_013F_00AA_02,
    48'h06_0241_00BB_00, 48'h06_0242_00BB_02, 48'h06_0307_0007_00,
    48'h06_0308_0007_02, 48'h03_0308_0000_02, 48'h06_0404_0001_02,
    48'h06_0405_0002_00, 48'h06_0417_0003_00, 48'h06_0418_0003_02,
    48'h03_0400_0000_00, 48'h03_0418_0000_02, 48'h10_0200_0000_01};

  // Free-running system clock.
  always #10 hclk = ~hclk;

  // The slave's own ready closes the bus loop.
  mpa_modbus_slave #(.SILENCE_CYC(50)) i_mpa_modbus_slave (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_byte,
    .tx_byte, .tx_ready, .link_speed, .link_format, .forced_do, .irq
  );

  mpa_link_master i_mpa_link_master (
    .hclk, .rx_byte, .tx_ready, .tx_byte
  );

  // Compares and counts.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A wait that runs out counts as a mismatch.
  task automatic hang();
    n_mismatch++;
    tally_and_finish();
  endtask

  // Waits for ready sampled high at an edge, taking read data with it.
  task automatic rdy();
    for (int k = 0; k <= 50; k++) begin
      if (k == 50) hang();
      @(posedge hclk);
      if (hreadyout === 1'b1) begin
        r = hrdata;
        break;
      end
    end
  endtask

  // One single-word bus transfer: address phase, then data phase.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Waits for n answer bytes, then leaves a line gap before going on.
  task automatic wait_n(input int n);
    for (int k = 0; k <= 5000; k++) begin
      if (k == 5000) hang();
      @(posedge hclk);
      if (i_mpa_link_master.got.size() >= n) break;
    end
    repeat (4) @(posedge hclk);
  endtask

  // One link exchange; ex is the expected exception code, 0 for success.
  task automatic xfer(input logic [7:0] fn, input logic [15:0] a,
                      input logic [15:0] v, input logic [7:0] ex);
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [7:0] x[$];
    q = {8'h01, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
    if (fn == FN_READ) q[4] = 8'h00;
    if (fn == FN_READ) q[5] = 8'h01;
    e = q;
    if (ex != 8'h00) e = {8'h01, fn | 8'h80, ex};
    else if (fn == FN_READ) e = {8'h01, fn, 8'h02, v[15:8], v[7:0]};
    i_mpa_link_master.got.delete();
    i_mpa_link_master.send(q, rtu, 1'b0);
    i_mpa_link_master.enc(e, rtu, x);
    wait_n(x.size());
    foreach (x[i]) chk(i_mpa_link_master.got[i], x[i]);
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, OFS_INT_EN, 32'h7);
    rd(OFS_INT_EN, 32'h7);
    rd(OFS_STATUS, 32'h4);
    rd(8'h1C, 32'h0);
    rd(OFS_LINK, 32'h0);
    xfer(FN_WRITE, LINK_FORMAT_ADDR, 16'h0008, 8'h00);
    chk(link_format, 32'h8);
    rtu = 1'b1;
    xfer(FN_WRITE, 16'h0200, 16'h0064, 8'h00);
    foreach (tbl[i]) begin
      xfer(tbl[i][47:40], tbl[i][39:24], tbl[i][23:8], tbl[i][7:0]);
    end
    xfer(FN_WRITE, LINK_SPEED_ADDR, 16'h0003, 8'h00);
    chk(link_speed, 32'h3);
    rd(OFS_LINK, 32'h0008_0003);
    i_mpa_link_master.slow = 1'b1;
    for (int n = 1; n <= 5; n++) begin
      xfer(FN_WRITE, FORCED_OUT_ADDR, 16'(n), 8'h00);
      chk(forced_do, 32'h1 << (n - 1));
    end
    xfer(FN_WRITE, FORCED_OUT_ADDR, 16'h0000, 8'h00);
    chk(forced_do, 32'h0);
    i_mpa_link_master.slow = 1'b0;
    xfer(FN_WRITE, ADJ_SELECT_ADDR, 16'h0009, 8'h02);
    xfer(FN_READ, ADJ_SELECT_ADDR, 16'h0000, 8'h00);
    xfer(FN_WRITE, UNLOCK_KEY_ADDR, 16'h0014, 8'h00);
    ahb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 32'h1400);
    xfer(FN_WRITE, ADJ_SELECT_ADDR, 16'h0009, 8'h00);
    xfer(FN_WRITE, TRIM_LO, 16'h0001, 8'h02);
    xfer(FN_WRITE, UNLOCK_KEY_ADDR, 16'h0016, 8'h00);
    ahb(1'b1, OFS_CTRL, 32'h1);
    xfer(FN_WRITE, TRIM_LO, 16'h0001, 8'h00);
    xfer(FN_WRITE, TRIM_HI, 16'h0002, 8'h00);
    ahb(1'b1, OFS_FAULT, 32'h7);
    rd(OFS_FAULT, 32'h7);
    xfer(FN_READ, CURRENT_FAULT_ADDR, 16'h0007, 8'h00);
    xfer(FN_READ, FAULT_HIST_LO, 16'h0007, 8'h00);
    rd(OFS_INT_STAT, 32'h5);
    chk(irq, 32'h1);
    ahb(1'b1, OFS_INT_CLR, 32'h7);
    rd(OFS_INT_STAT, 32'h0);
    repeat (2) @(negedge hclk);
    chk(irq, 32'h0);
    bq = {8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h01};
    i_mpa_link_master.got.delete();
    i_mpa_link_master.send(bq, 1'b1, 1'b1);
    repeat (200) @(posedge hclk);
    chk(i_mpa_link_master.got.size(), 32'h0);
    rd(OFS_INT_STAT, 32'h2);
    repeat (2) @(negedge hclk);
    chk(irq, 32'h1);
    ahb(1'b1, OFS_INT_EN, 32'h0);
    repeat (2) @(negedge hclk);
    chk(irq, 32'h0);
    tally_and_finish();
  end
endmodule
